// >>> verilog/dct_pkg.sv
// constants for the two down counters: host offsets, command bits, clock dividers
// assumes a single 250 MHz clock and a byte-wide host port with one-cycle strobes
// Notes on behaviour
// - general counter is 16 bits; on-board clock picks 10MHz or 100KHz
// - general output rises on pulse reaching zero; next pulse reloads, drops it
// - pin mode: count external rising edges only while external gate is high
// - external counting refreshes the readable count every fourth pulse and on load or zero commands
// - on-board mode: general counter uses selected clock, no gating, counts every tick while run is set
// - write-only command byte at 15: select, latch, gate off/on, stop/run, load, zero
// - load bytes at 12,13,14 in any order; load command moves them in
// - latch captures selected count without disturbing counting
// - data reads return captured value, low byte at lowest offset
// - run and stop act any time; stopped counter ignores input edges
// - pacer: gating off counts every edge, gating on only while gate high; general counter gate set by pin mode, not these bits
// - zero while running clears count; counting then continues
// - pacer counter clocked at 10MHz or 1MHz by its rate bit
// - pacer output high one input period at zero, then reload and repeat
// - pin function bit routes header lines to counter gates and general counter clock
`default_nettype none
package dct_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int RATE_10M_HZ = 10_000_000;
    localparam int RATE_1M_HZ = 1_000_000;
    localparam int RATE_100K_HZ = 100_000;
    localparam int DIV_W = 12;
    localparam logic [DIV_W-1:0] LAST_10M = DIV_W'(CLK_HZ / RATE_10M_HZ - 1);
    localparam logic [DIV_W-1:0] LAST_1M = DIV_W'(CLK_HZ / RATE_1M_HZ - 1);
    localparam logic [DIV_W-1:0] LAST_100K = DIV_W'(CLK_HZ / RATE_100K_HZ - 1);
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_DATA_LOW = 4'hc;
    localparam logic [ADDR_W-1:0] ADDR_DATA_MID = 4'hd;
    localparam logic [ADDR_W-1:0] ADDR_DATA_HIGH = 4'he;
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'hf;
    localparam int CMD_SELECT = 7;
    localparam int CMD_LATCH = 6;
    localparam int CMD_GATE_OFF = 5;
    localparam int CMD_GATE_ON = 4;
    localparam int CMD_STOP = 3;
    localparam int CMD_RUN = 2;
    localparam int CMD_LOAD = 1;
    localparam int CMD_ZERO = 0;
    localparam int PACER_W = 24;
    localparam int GP_W = 16;
    localparam int LOAD_W = 24;
    localparam logic [1:0] EXT_REFRESH_LAST = 2'h3;
    localparam int PIN_GATE0 = 0;
    localparam int PIN_GATE1 = 1;
    localparam int PIN_CLK1 = 2;
endpackage
`default_nettype wire

// >>> verilog/cnt_ctrl_if.sv
// control bundle between the host-facing top and one down counter unit
// assumes both ends sit on the same clock
`default_nettype none
interface cnt_ctrl_if;
    logic tick;
    logic gate;
    logic gate_force;
    logic gate_bypass;
    logic ext_mode;
    logic cmd_stb;
    logic [7:0] cmd;
    logic [dct_pkg::LOAD_W-1:0] load_value;
    logic [dct_pkg::LOAD_W-1:0] latched;
    logic out;
    modport unit (input tick, gate, gate_force, gate_bypass, ext_mode, cmd_stb, cmd,
        load_value, output latched, out);
    modport ctrl (output tick, gate, gate_force, gate_bypass, ext_mode, cmd_stb, cmd,
        load_value, input latched, out);
endinterface
`default_nettype wire

// >>> verilog/down_count_unit.sv
// one programmable down counter with reload, gating, latch and zero output
// assumes tick is a one-cycle enable and commands arrive as one-cycle strobes
`default_nettype none
module down_count_unit #(
    parameter int W = dct_pkg::GP_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    cnt_ctrl_if.unit ctl
);
    if (W < 2 || W > dct_pkg::LOAD_W) begin : g_bad_width
        $error("counter width out of range");
    end

    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] init;
        logic [W-1:0] vis;
        logic [W-1:0] latch;
        logic out;
        logic run;
        logic gate_en;
        logic [1:0] pulses;
    } unit_s;

    unit_s r;
    unit_s nxt;
    logic gate_ok;
    logic step;
    logic refresh;

    // gate resolution: bypass ignores gate, force or enable obeys it
    assign gate_ok = ctl.gate_bypass | ~(r.gate_en | ctl.gate_force) | ctl.gate;
    assign step = ctl.tick & r.run & gate_ok;
    assign refresh = ~ctl.ext_mode | (step & (r.pulses == dct_pkg::EXT_REFRESH_LAST));

    // counting first, then any command of this cycle on top
    always_comb begin
        nxt = r;
        if (step) begin
            if (r.count == '0) begin
                nxt.count = r.init;
                nxt.out = 1'b0;
            end else begin
                nxt.count = r.count - 1'b1;
                nxt.out = (r.count == W'(1));
            end
            if (ctl.ext_mode) begin
                nxt.pulses = r.pulses + 1'b1;
            end
        end
        if (ctl.cmd_stb) begin
            if (ctl.cmd[dct_pkg::CMD_LATCH]) begin
                nxt.latch = r.vis;
            end
            if (ctl.cmd[dct_pkg::CMD_GATE_OFF]) begin
                nxt.gate_en = 1'b0;
            end else if (ctl.cmd[dct_pkg::CMD_GATE_ON]) begin
                nxt.gate_en = 1'b1;
            end
            if (ctl.cmd[dct_pkg::CMD_STOP]) begin
                nxt.run = 1'b0;
            end else if (ctl.cmd[dct_pkg::CMD_RUN]) begin
                nxt.run = 1'b1;
            end
            if (ctl.cmd[dct_pkg::CMD_LOAD]) begin
                nxt.init = ctl.load_value[W-1:0];
                nxt.count = ctl.load_value[W-1:0];
                nxt.out = 1'b0;
            end
            if (ctl.cmd[dct_pkg::CMD_ZERO]) begin
                nxt.count = '0;
            end
        end
        // readable copy lags in external mode until the fourth pulse
        if (refresh || (ctl.cmd_stb
                && (ctl.cmd[dct_pkg::CMD_LOAD] || ctl.cmd[dct_pkg::CMD_ZERO]))) begin
            nxt.vis = nxt.count;
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign ctl.latched = dct_pkg::LOAD_W'(r.latch);
    assign ctl.out = r.out;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_latch_cmd;
        ctl.cmd_stb && ctl.cmd[dct_pkg::CMD_LATCH];
    endsequence
    sequence s_quiet;
        !ctl.cmd_stb;
    endsequence
    sequence s_hit_zero;
        s_quiet and (step && r.count == W'(1));
    endsequence

    a_zero_cmd_clears: assert property (
        ctl.cmd_stb && ctl.cmd[dct_pkg::CMD_ZERO] |=> r.count == '0)
        else $error("zero command did not clear count");
    a_stop_holds_count: assert property (
        !r.run ##0 s_quiet |=> $stable(r.count))
        else $error("stopped counter moved");
    a_latch_captures: assert property (
        s_latch_cmd |=> r.latch == $past(r.vis))
        else $error("latch missed visible count");
    a_latch_holds: assert property (
        !(ctl.cmd_stb && ctl.cmd[dct_pkg::CMD_LATCH]) |=> $stable(r.latch))
        else $error("latched value changed without latch");
    a_out_at_zero: assert property (
        s_hit_zero |=> r.out && r.count == '0)
        else $error("output not high on reaching zero");
    a_reload_on_pulse: assert property (
        s_quiet and (step && r.out) |=> !r.out && r.count == $past(r.init))
        else $error("no reload after zero");
    a_gate_low_holds: assert property (
        s_quiet and (!ctl.gate_bypass && (r.gate_en || ctl.gate_force) && !ctl.gate)
        |=> $stable(r.count))
        else $error("counted while gate low");
    a_ext_refresh: assert property (
        s_quiet and (ctl.ext_mode && !(step && r.pulses == dct_pkg::EXT_REFRESH_LAST))
        |=> $stable(r.vis))
        else $error("visible count changed between refreshes");
endmodule
`default_nettype wire

// >>> verilog/dual_down_counter_timer.sv
// host-facing top: byte registers, clock dividers, pin sync, two counter units
// assumes host strobes are one-cycle pulses on i_clock; header pins are asynchronous
`default_nettype none
module dual_down_counter_timer (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [dct_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_pin_function_select,
    input wire logic i_pacer_rate_select,
    input wire logic i_gp_rate_select,
    input wire logic i_gate0_pin,
    input wire logic i_gate1_pin,
    input wire logic i_clk1_pin,
    output logic o_pacer_out,
    output logic o_gp_out
);
    typedef struct packed {
        logic [dct_pkg::DIV_W-1:0] div_10m;
        logic [dct_pkg::DIV_W-1:0] div_1m;
        logic [dct_pkg::DIV_W-1:0] div_100k;
        logic t10m;
        logic t1m;
        logic t100k;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic clk1_prev;
        logic [dct_pkg::LOAD_W-1:0] load_buf;
        logic last_sel;
        logic [7:0] rdata;
    } top_s;

    top_s r;
    top_s nxt;
    logic cmd_wr;
    logic [dct_pkg::LOAD_W-1:0] sel_latched;

    cnt_ctrl_if pacer_ifc ();
    cnt_ctrl_if gp_ifc ();

    assign cmd_wr = i_wr_stb && (i_addr == dct_pkg::ADDR_COMMAND);
    assign sel_latched = r.last_sel ? gp_ifc.latched : pacer_ifc.latched;

    // dividers, pin synchronisers, load bytes and read data
    always_comb begin
        nxt = r;
        nxt.t10m = (r.div_10m == dct_pkg::LAST_10M);
        nxt.t1m = (r.div_1m == dct_pkg::LAST_1M);
        nxt.t100k = (r.div_100k == dct_pkg::LAST_100K);
        nxt.div_10m = nxt.t10m ? '0 : r.div_10m + 1'b1;
        nxt.div_1m = nxt.t1m ? '0 : r.div_1m + 1'b1;
        nxt.div_100k = nxt.t100k ? '0 : r.div_100k + 1'b1;
        nxt.sync1 = {i_clk1_pin, i_gate1_pin, i_gate0_pin};
        nxt.sync2 = r.sync1;
        nxt.clk1_prev = r.sync2[dct_pkg::PIN_CLK1];
        if (i_wr_stb) begin
            unique case (i_addr)
                dct_pkg::ADDR_DATA_LOW: nxt.load_buf[7:0] = i_wdata;
                dct_pkg::ADDR_DATA_MID: nxt.load_buf[15:8] = i_wdata;
                dct_pkg::ADDR_DATA_HIGH: nxt.load_buf[23:16] = i_wdata;
                default: ;
            endcase
        end
        if (cmd_wr && i_wdata[dct_pkg::CMD_LATCH]) begin
            nxt.last_sel = i_wdata[dct_pkg::CMD_SELECT];
        end
        if (i_rd_stb) begin
            unique case (i_addr)
                dct_pkg::ADDR_DATA_LOW: nxt.rdata = sel_latched[7:0];
                dct_pkg::ADDR_DATA_MID: nxt.rdata = sel_latched[15:8];
                dct_pkg::ADDR_DATA_HIGH: nxt.rdata = sel_latched[23:16];
                default: nxt.rdata = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // pacer counter: on-board clock, gate from header only in pin mode
    assign pacer_ifc.tick = i_pacer_rate_select ? r.t1m : r.t10m;
    assign pacer_ifc.gate = i_pin_function_select | r.sync2[dct_pkg::PIN_GATE0];
    assign pacer_ifc.gate_force = 1'b0;
    assign pacer_ifc.gate_bypass = 1'b0;
    assign pacer_ifc.ext_mode = 1'b0;
    assign pacer_ifc.cmd_stb = cmd_wr && !i_wdata[dct_pkg::CMD_SELECT];
    assign pacer_ifc.cmd = i_wdata;
    assign pacer_ifc.load_value = r.load_buf;

    // general counter: header clock and gate in pin mode, else on-board clock
    assign gp_ifc.tick = i_pin_function_select ? (i_gp_rate_select ? r.t100k : r.t10m)
        : (r.sync2[dct_pkg::PIN_CLK1] & ~r.clk1_prev);
    assign gp_ifc.gate = r.sync2[dct_pkg::PIN_GATE1];
    assign gp_ifc.gate_force = ~i_pin_function_select;
    assign gp_ifc.gate_bypass = i_pin_function_select;
    assign gp_ifc.ext_mode = ~i_pin_function_select;
    assign gp_ifc.cmd_stb = cmd_wr && i_wdata[dct_pkg::CMD_SELECT];
    assign gp_ifc.cmd = i_wdata;
    assign gp_ifc.load_value = r.load_buf;

    down_count_unit #(.W(dct_pkg::PACER_W)) u_pacer (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .ctl(pacer_ifc.unit)
    );

    down_count_unit #(.W(dct_pkg::GP_W)) u_gp (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .ctl(gp_ifc.unit)
    );

    assign o_rdata = r.rdata;
    assign o_pacer_out = pacer_ifc.out;
    assign o_gp_out = gp_ifc.out;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_cmd_routing: assert property (
        cmd_wr |-> (pacer_ifc.cmd_stb != gp_ifc.cmd_stb)
            && (gp_ifc.cmd_stb == i_wdata[dct_pkg::CMD_SELECT]))
        else $error("command reached wrong counter");
    a_read_low_byte: assert property (
        i_rd_stb && i_addr == dct_pkg::ADDR_DATA_LOW |=> o_rdata == $past(sel_latched[7:0]))
        else $error("low data byte wrong");
    a_load_byte_kept: assert property (
        i_wr_stb && i_addr == dct_pkg::ADDR_DATA_MID |=> r.load_buf[15:8] == $past(i_wdata))
        else $error("middle load byte not stored");
    a_gp_ext_gated: assert property (
        !i_pin_function_select |-> gp_ifc.gate_force && !gp_ifc.gate_bypass)
        else $error("pin mode gate not applied");
endmodule
`default_nettype wire

// >>> sim/pulse_source.sv
// partner model: external pulse source driving the general counter clock pin
// assumes the bench calls send() from its own procedure on the shared clock
`default_nettype none
module pulse_source (
    input wire logic i_clock,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // pin idles low between bursts, so no stray edge reaches the counter
    initial o_pin = 1'b0;

    // burst of n rising edges, four clocks low then four clocks high
    task automatic send(input int n);
        repeat (n) begin
            repeat (4) @(negedge i_clock);
            o_pin = 1'b1;
            repeat (4) @(negedge i_clock);
            o_pin = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the dual down counter timer: host byte port and pins
// assumes 250 MHz clock, stimulus on falling edges, the pulse source as clk1 pin
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) begin \
            miscompares++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_sys_rst, i_wr_stb, i_rd_stb, i_pin_function_select;
    logic i_pacer_rate_select, i_gp_rate_select, i_gate0_pin, i_gate1_pin, i_clk1_pin;
    logic [dct_pkg::ADDR_W-1:0] i_addr;
    logic [7:0] i_wdata, o_rdata, d, base;
    logic o_pacer_out, o_gp_out, sel;
    logic [23:0] v1, v2;
    int miscompares = 0;
    int num_checks = 0;
    int w;
    int w_exp;

    dual_down_counter_timer dual_down_counter_timer_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pin_function_select(i_pin_function_select),
        .i_pacer_rate_select(i_pacer_rate_select), .i_gp_rate_select(i_gp_rate_select),
        .i_gate0_pin(i_gate0_pin), .i_gate1_pin(i_gate1_pin), .i_clk1_pin(i_clk1_pin),
        .o_pacer_out(o_pacer_out), .o_gp_out(o_gp_out));
    pulse_source pulse_source_inst (.i_clock(i_clock), .o_pin(i_clk1_pin));

    // 4 ns clock
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(negedge i_clock); i_addr = a; i_wdata = x; i_wr_stb = 1'b1;
        @(negedge i_clock); i_wr_stb = 1'b0;
    endtask

    // one-cycle read strobe, data taken once registered
    task automatic rd(input logic [3:0] a, output logic [7:0] x);
        @(negedge i_clock); i_addr = a; i_rd_stb = 1'b1;
        @(negedge i_clock); i_rd_stb = 1'b0;
        @(negedge i_clock); x = o_rdata;
    endtask

    // latch command then three data byte reads
    task automatic rd24(input logic [7:0] cmd, output logic [23:0] v);
        logic [7:0] b;
        wr(4'hf, cmd);
        rd(4'hc, b); v[7:0] = b;
        rd(4'hd, b); v[15:8] = b;
        rd(4'he, b); v[23:16] = b;
    endtask

    // cycles spent high by the chosen output, after waiting for its rise
    task automatic measure(input logic s, output int hi);
        int n;
        n = 0;
        hi = 0;
        while ((s ? o_gp_out : o_pacer_out) !== 1'b1 && n < 20000) begin
            @(negedge i_clock); n++;
        end
        while ((s ? o_gp_out : o_pacer_out) === 1'b1 && hi < 20000) begin
            @(negedge i_clock); hi++;
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog: the tests need well under 20000 cycles
    initial begin
        repeat (40000) @(posedge i_clock);
        miscompares++;
        stop_test();
    end

    // main sequence
    initial begin
        {i_sys_rst, i_pin_function_select} = 2'h3;
        {i_wr_stb, i_rd_stb, i_pacer_rate_select, i_gp_rate_select} = 4'h0;
        {i_gate0_pin, i_gate1_pin, i_addr, i_wdata} = 14'h0000;
        repeat (20) @(posedge i_clock);
        @(negedge i_clock); i_sys_rst = 1'b0;
        rd(4'hc, d); `CHK("data after reset", 8'h00, d)
        rd(4'h3, d); `CHK("unmapped read", 8'h00, d)
        // pacer load, bytes out of order
        wr(4'he, 8'h12); wr(4'hc, 8'h56); wr(4'hd, 8'h34); wr(4'hf, 8'h02);
        rd24(8'h40, v1); `CHK("pacer latch", 24'h12_3456, v1)
        wr(4'hc, 8'hcd); wr(4'hd, 8'hab); wr(4'hf, 8'h82);
        rd24(8'hc0, v1); `CHK("general latch", 24'h00_abcd, v1)
        rd24(8'h40, v1); `CHK("pacer untouched", 24'h12_3456, v1)
        // running pacer: held capture, live count moves
        wr(4'hf, 8'h04); repeat (200) @(negedge i_clock);
        rd(4'hc, d); `CHK("capture held", 8'h56, d)
        rd24(8'h40, v1); `CHK("count moved", 1'b1, v1 < 24'h12_3456)
        wr(4'hf, 8'h08); rd24(8'h40, v1); repeat (100) @(negedge i_clock);
        rd24(8'h40, v2); `CHK("stopped count", v1, v2)
        // pacer gating from the gate0 pin held low
        i_pin_function_select = 1'b0;
        wr(4'hf, 8'h10); wr(4'hf, 8'h04); rd24(8'h40, v1);
        repeat (100) @(negedge i_clock);
        rd24(8'h40, v2); `CHK("gated pacer", v1, v2)
        i_gate0_pin = 1'b1;
        repeat (100) @(negedge i_clock);
        rd24(8'h40, v2); `CHK("gate high pacer", 1'b1, v2 < v1)
        i_gate0_pin = 1'b0;
        repeat (4) @(negedge i_clock);
        rd24(8'h40, v1);
        wr(4'hf, 8'h20); repeat (100) @(negedge i_clock);
        rd24(8'h40, v2); `CHK("ungated pacer", 1'b1, v2 < v1)
        wr(4'hf, 8'h08);
        // output pulse widths per clock source, general gate pin low
        i_pin_function_select = 1'b1;
        wr(4'hf, 8'h90);
        for (int k = 0; k < 4; k++) begin
            sel = (k >= 2);
            i_pacer_rate_select = (k == 1);
            i_gp_rate_select = (k == 2);
            base = sel ? 8'h80 : 8'h00;
            w_exp = dct_pkg::CLK_HZ / dct_pkg::RATE_10M_HZ;
            if (k == 1) begin
                w_exp = dct_pkg::CLK_HZ / dct_pkg::RATE_1M_HZ;
            end
            if (k == 2) begin
                w_exp = dct_pkg::CLK_HZ / dct_pkg::RATE_100K_HZ;
            end
            wr(4'hc, 8'h01); wr(4'hd, 8'h00); wr(4'he, 8'h00);
            wr(4'hf, base | 8'h02); wr(4'hf, base | 8'h04);
            measure(sel, w);
            `CHK("pulse width", w_exp, w)
            wr(4'hf, base | 8'h08);
        end
        // external pulse counting on the general counter
        i_pin_function_select = 1'b0;
        i_gate1_pin = 1'b1;
        wr(4'hc, 8'h64); wr(4'hd, 8'h00); wr(4'hf, 8'h82); wr(4'hf, 8'ha0); wr(4'hf, 8'h84);
        pulse_source_inst.send(4); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("ext four", 24'h00_0060, v1)
        pulse_source_inst.send(3); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("ext no refresh", 24'h00_0060, v1)
        pulse_source_inst.send(1); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("ext refresh", 24'h00_005c, v1)
        i_gate1_pin = 1'b0;
        pulse_source_inst.send(4); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("ext gate low", 24'h00_005c, v1)
        i_gate1_pin = 1'b1;
        wr(4'hf, 8'h81); rd24(8'hc0, v1); `CHK("zero running", 24'h00_0000, v1)
        pulse_source_inst.send(4); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("after zero", 24'h00_0061, v1)
        wr(4'hf, 8'h88); pulse_source_inst.send(4); repeat (10) @(negedge i_clock);
        rd24(8'hc0, v1); `CHK("ext stopped", 24'h00_0061, v1)
        // second reset in mid-run clears counts, captures and read data
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        i_sys_rst = 1'b0;
        `CHK("rdata after reset", 8'h00, o_rdata)
        `CHK("gp out after reset", 1'b0, o_gp_out)
        rd24(8'h40, v1); `CHK("pacer after reset", 24'h00_0000, v1)
        stop_test();
    end
endmodule
`default_nettype wire
